// ===== mab_array_ctrl.sv
// Memory array bus controller: strobes, addressing, data and refresh
`timescale 1ns/10ps

module mab_array_ctrl
   import mab_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic req_valid_i,
   input wire mab_req_s req_i,
   output logic req_ready_o,
   input wire logic refresh_req_i,
   output logic done_o,
   output logic err_o,
   output mab_rsp_s rsp_o,
   output logic [`MAB_NUM_MODULES-1:0] module_present_o,
   output logic [`MAB_NUM_MODULES-1:0] module_sel_n_o,
   output logic [`MAB_BANK_W-1:0] bank_pick_o,
   output logic [`MAB_ADDR_W-1:0] addr_o,
   output logic row_strobe_n_o,
   output logic col_strobe_n_o,
   output logic write_strobe_n_o,
   output logic read_drive_enable_n_o,
   output logic refresh_cycle_n_o,
   input wire logic [`MAB_DATA_W-1:0] data_n_i,
   output logic [`MAB_DATA_W-1:0] data_n_o,
   output logic data_n_oe_o,
   input wire logic [`MAB_CHECK_W-1:0] check_bits_n_i,
   output logic [`MAB_CHECK_W-1:0] check_bits_n_o,
   output logic check_bits_n_oe_o,
   input wire logic [2*`MAB_NUM_MODULES-1:0] module_presence_code_n_i
);

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [`MAB_DATA_W-1:0] dat_s1_q, dat_s2_q;
   logic [`MAB_CHECK_W-1:0] chk_s1_q, chk_s2_q;
   logic [2*`MAB_NUM_MODULES-1:0] fp_s1_q, fp_s2_q;
   logic [`MAB_NUM_MODULES-1:0] present_q, present_d;

   // Module present only when both of its lines are asserted (low)
   genvar g;
   generate
      for (g = 0; g < `MAB_NUM_MODULES; g = g + 1) begin : g_fp
         always_comb begin
            present_d[g] = ~fp_s2_q[2*g] & ~fp_s2_q[2*g+1];
         end
      end
   endgenerate

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         dat_s1_q <= '0;
         dat_s2_q <= '0;
         chk_s1_q <= '0;
         chk_s2_q <= '0;
         fp_s1_q <= '1;
         fp_s2_q <= '1;
         present_q <= '0;
      end else begin
         dat_s1_q <= data_n_i;
         dat_s2_q <= dat_s1_q;
         chk_s1_q <= check_bits_n_i;
         chk_s2_q <= chk_s1_q;
         fp_s1_q <= module_presence_code_n_i;
         fp_s2_q <= fp_s1_q;
         present_q <= present_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Refresh row
   logic [`MAB_ADDR_W-1:0] ref_row;
   logic ref_advance;

   mab_refresh_row u_ref_row (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .advance_i(ref_advance),
      .row_o(ref_row)
   );

   ////////////////////////////////////////////////////////////////////////
   // Reference sequencer
   mab_state_e state_q, state_d;
   logic [`MAB_CNT_W-1:0] cnt_q, cnt_d;
   mab_req_s cur_q, cur_d;
   logic refr_q, refr_d, ready_q, ready_d, done_q, done_d, err_q, err_d;
   mab_rsp_s rsp_q, rsp_d;
   logic [`MAB_NUM_MODULES-1:0] sel_n_q, sel_n_d;
   logic [`MAB_BANK_W-1:0] bank_q, bank_d;
   logic [`MAB_ADDR_W-1:0] addr_q, addr_d;
   logic ras_n_q, ras_n_d, cas_n_q, cas_n_d, wrt_n_q, wrt_n_d;
   logic rde_n_q, rde_n_d, refn_q, refn_d, doe_q, doe_d;
   logic [`MAB_DATA_W-1:0] dout_q, dout_d;
   logic [`MAB_CHECK_W-1:0] cout_q, cout_d;
   logic mod_ok;

   // Unknown indices and absent modules are refused, not referenced
   always_comb begin
      mod_ok = 1'b0;
      if (req_i.addr.module_idx < `MAB_MOD_W'(`MAB_NUM_MODULES)) begin
         mod_ok = present_q[req_i.addr.module_idx];
      end
   end

   always_comb begin
      state_d = state_q;
      cnt_d = (state_q == MAB_IDLE) ? cnt_q : cnt_q - 1'b1;
      cur_d = cur_q;
      refr_d = refr_q;
      done_d = 1'b0;
      err_d = 1'b0;
      rsp_d = rsp_q;
      sel_n_d = sel_n_q;
      bank_d = bank_q;
      addr_d = addr_q;
      ras_n_d = ras_n_q;
      cas_n_d = cas_n_q;
      wrt_n_d = wrt_n_q;
      rde_n_d = rde_n_q;
      refn_d = refn_q;
      doe_d = doe_q;
      dout_d = dout_q;
      cout_d = cout_q;
      ref_advance = 1'b0;
      case (state_q)
         MAB_IDLE: begin
            // Refresh wins over a waiting reference
            if (refresh_req_i) begin
               refr_d = 1'b1;
               refn_d = 1'b0;
               sel_n_d = '0;
               addr_d = ref_row;
               cnt_d = `MAB_CNT_W'(`MAB_ROW_SETUP_CYC);
               state_d = MAB_ROW;
            end else if (req_valid_i && ready_q) begin
               err_d = !mod_ok;
               if (mod_ok) begin
                  cur_d = req_i;
                  refr_d = 1'b0;
                  sel_n_d = ~(`MAB_NUM_MODULES'(1) << req_i.addr.module_idx);
                  bank_d = req_i.addr.bank;
                  addr_d = req_i.addr.row;
                  doe_d = req_i.write;
                  dout_d = ~req_i.data;
                  cout_d = ~req_i.check;
                  rde_n_d = req_i.write;
                  cnt_d = `MAB_CNT_W'(`MAB_ROW_SETUP_CYC);
                  state_d = MAB_ROW;
               end
            end
         end
         MAB_ROW: begin
            if (cnt_q <= `MAB_CNT_W'(1)) begin
               ras_n_d = 1'b0;
               cnt_d = `MAB_CNT_W'(`MAB_ROW_HOLD_CYC);
               state_d = MAB_RAS;
            end
         end
         MAB_RAS: begin
            if (cnt_q <= `MAB_CNT_W'(1)) begin
               if (refr_q) begin
                  cnt_d = `MAB_CNT_W'(`MAB_COL_PULSE_CYC);
                  state_d = MAB_CAS; // Row-only cycle, no column strobe
               end else begin
                  addr_d = cur_q.addr.col;
                  cnt_d = `MAB_CNT_W'(`MAB_COL_SETUP_CYC);
                  state_d = MAB_COL;
               end
            end
         end
         MAB_COL: begin
            if (cnt_q <= `MAB_CNT_W'(1)) begin
               cas_n_d = 1'b0;
               wrt_n_d = ~cur_q.write;
               cnt_d = `MAB_CNT_W'(`MAB_COL_PULSE_CYC);
               state_d = MAB_CAS;
            end
         end
         MAB_CAS: begin
            if (cnt_q <= `MAB_CNT_W'(1)) begin
               // Sampled after two sync flops; pulse is long enough
               if (!refr_q && !cur_q.write) begin
                  rsp_d = ~{dat_s2_q, chk_s2_q};
               end
               ref_advance = refr_q;
               done_d = ~refr_q;
               ras_n_d = 1'b1;
               cas_n_d = 1'b1;
               wrt_n_d = 1'b1;
               rde_n_d = 1'b1;
               refn_d = 1'b1;
               doe_d = 1'b0;
               sel_n_d = '1;
               cnt_d = `MAB_CNT_W'(`MAB_PRECHARGE_CYC);
               state_d = MAB_PRE;
            end
         end
         MAB_PRE: begin
            if (cnt_q <= `MAB_CNT_W'(1)) begin
               state_d = MAB_IDLE;
            end
         end
         default: begin
            state_d = MAB_IDLE;
         end
      endcase
      ready_d = (state_d == MAB_IDLE) && !refresh_req_i;
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         state_q <= MAB_IDLE;
         cnt_q <= '0;
         cur_q <= '0;
         refr_q <= 1'b0;
         ready_q <= 1'b0;
         done_q <= 1'b0;
         err_q <= 1'b0;
         rsp_q <= '0;
         sel_n_q <= '1;
         bank_q <= '0;
         addr_q <= '0;
         ras_n_q <= 1'b1;
         cas_n_q <= 1'b1;
         wrt_n_q <= 1'b1;
         rde_n_q <= 1'b1;
         refn_q <= 1'b1;
         doe_q <= 1'b0;
         dout_q <= '1;
         cout_q <= '1;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         cur_q <= cur_d;
         refr_q <= refr_d;
         ready_q <= ready_d;
         done_q <= done_d;
         err_q <= err_d;
         rsp_q <= rsp_d;
         sel_n_q <= sel_n_d;
         bank_q <= bank_d;
         addr_q <= addr_d;
         ras_n_q <= ras_n_d;
         cas_n_q <= cas_n_d;
         wrt_n_q <= wrt_n_d;
         rde_n_q <= rde_n_d;
         refn_q <= refn_d;
         doe_q <= doe_d;
         dout_q <= dout_d;
         cout_q <= cout_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign req_ready_o = ready_q;
   assign done_o = done_q;
   assign err_o = err_q;
   assign rsp_o = rsp_q;
   assign module_present_o = present_q;
   assign module_sel_n_o = sel_n_q;
   assign bank_pick_o = bank_q;
   assign addr_o = addr_q;
   assign row_strobe_n_o = ras_n_q;
   assign col_strobe_n_o = cas_n_q;
   assign write_strobe_n_o = wrt_n_q;
   assign read_drive_enable_n_o = rde_n_q;
   assign refresh_cycle_n_o = refn_q;
   assign data_n_o = dout_q;
   assign data_n_oe_o = doe_q;
   assign check_bits_n_o = cout_q;
   assign check_bits_n_oe_o = doe_q;

endmodule

// ===== mab_regs.svh
// Timing and field constants for the memory array bus controller
`ifndef MAB_REGS_SVH
`define MAB_REGS_SVH

`define MAB_CLK_PERIOD_NS 25
// Strobe timing, in ns as chosen for the array chips
`define MAB_T_ROW_SETUP_NS 25
`define MAB_T_ROW_HOLD_NS 50
`define MAB_T_COL_SETUP_NS 25
`define MAB_T_COL_PULSE_NS 75
`define MAB_T_PRECHARGE_NS 50
// Least times round up to whole cycles
`define MAB_CYC(ns) (((ns) + `MAB_CLK_PERIOD_NS - 1) / `MAB_CLK_PERIOD_NS)
`define MAB_ROW_SETUP_CYC `MAB_CYC(`MAB_T_ROW_SETUP_NS)
`define MAB_ROW_HOLD_CYC `MAB_CYC(`MAB_T_ROW_HOLD_NS)
`define MAB_COL_SETUP_CYC `MAB_CYC(`MAB_T_COL_SETUP_NS)
`define MAB_COL_PULSE_CYC `MAB_CYC(`MAB_T_COL_PULSE_NS)
`define MAB_PRECHARGE_CYC `MAB_CYC(`MAB_T_PRECHARGE_NS)

`define MAB_NUM_MODULES 5
`define MAB_DATA_W 32
`define MAB_CHECK_W 7
`define MAB_ADDR_W 8
`define MAB_BANK_W 2
`define MAB_MOD_W 3
`define MAB_CNT_W 3
`define MAB_REF_ROW_RESET 8'h00

`endif

// ===== mab_pkg.sv
// Types shared by the memory array bus controller
`include "mab_regs.svh"

package mab_pkg;

   typedef struct packed {
      logic [`MAB_MOD_W-1:0] module_idx;
      logic [`MAB_BANK_W-1:0] bank;
      logic [`MAB_ADDR_W-1:0] row;
      logic [`MAB_ADDR_W-1:0] col;
   } mab_addr_s;

   typedef struct packed {
      logic write;
      mab_addr_s addr;
      logic [`MAB_DATA_W-1:0] data;
      logic [`MAB_CHECK_W-1:0] check;
   } mab_req_s;

   typedef struct packed {
      logic [`MAB_DATA_W-1:0] data;
      logic [`MAB_CHECK_W-1:0] check;
   } mab_rsp_s;

   typedef enum logic [2:0] {
      MAB_IDLE = 3'h0,
      MAB_ROW = 3'h1,
      MAB_RAS = 3'h3,
      MAB_COL = 3'h7,
      MAB_CAS = 3'h6,
      MAB_PRE = 3'h4
   } mab_state_e;

endpackage

// ===== mab_refresh_row.sv
// Refresh row address counter for the memory array bus
`timescale 1ns/10ps

module mab_refresh_row
   import mab_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic advance_i,
   output logic [`MAB_ADDR_W-1:0] row_o
);

   logic [`MAB_ADDR_W-1:0] row_q;
   logic [`MAB_ADDR_W-1:0] row_d;

   // Walks all 256 rows, wrapping naturally
   always_comb begin
      row_d = row_q;
      if (advance_i) begin
         row_d = row_q + 8'h01;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         row_q <= `MAB_REF_ROW_RESET;
      end else begin
         row_q <= row_d;
      end
   end

   assign row_o = row_q;

endmodule

// ===== mab_array_model.sv
// Behavioural model of the memory array modules
`timescale 1ns/10ps
module mab_array_model
   import mab_pkg::*;
#(parameter logic [4:0] ABSENT = 5'h10)
(
   input wire logic sys_clk_i,
   input wire logic [4:0] sel_n_i,
   input wire logic [1:0] bank_i,
   input wire logic [7:0] addr_i,
   input wire logic row_n_i,
   input wire logic col_n_i,
   input wire logic wr_n_i,
   input wire logic rd_n_i,
   input wire logic [38:0] pins_i,
   output logic [38:0] pins_o,
   output logic [9:0] pres_n_o
);
   logic [38:0] mem [int];
   logic [7:0] row_q = 8'h00;
   logic [38:0] alt_q = 39'h0;
   int key;
   assign key = int'({sel_n_i, bank_i, row_q, addr_i});
   always_comb begin
      for (int g = 0; g < 5; g++) begin
         pres_n_o[2*g+:2] = ABSENT[g] ? 2'h3 : 2'h0;
      end
   end
   ////////////////////////////////////////
   always @(negedge row_n_i) row_q = addr_i;
   // Released lines toggle so a stale word never looks valid
   always @(posedge sys_clk_i) begin
      alt_q <= ~pins_o;
      if (!col_n_i && !wr_n_i) mem[key] = ~pins_i;
   end
   always @* begin
      if (!rd_n_i && !col_n_i && mem.exists(key)) pins_o = ~mem[key];
      else pins_o = alt_q;
   end
endmodule

// ===== mab_array_ctrl_asserts.sv
// Port checks for the memory array bus controller
`timescale 1ns/10ps
module mab_array_ctrl_asserts
   import mab_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic req_valid_i,
   input wire mab_req_s req_i,
   input wire logic req_ready_o,
   input wire logic refresh_req_i,
   input wire logic done_o,
   input wire logic err_o,
   input wire logic [4:0] module_present_o,
   input wire logic [4:0] module_sel_n_o,
   input wire logic [7:0] addr_o,
   input wire logic row_strobe_n_o,
   input wire logic col_strobe_n_o,
   input wire logic write_strobe_n_o,
   input wire logic read_drive_enable_n_o,
   input wire logic refresh_cycle_n_o,
   input wire logic data_n_oe_o,
   input wire logic check_bits_n_oe_o
);
   logic tk, ok;
   assign tk = req_ready_o && req_valid_i && !refresh_req_i;
   assign ok = req_i.addr.module_idx < 3'h5
      && module_present_o[req_i.addr.module_idx];
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   ////////////////////////////////////////
   AST_ONE_SEL: assert property (
      refresh_cycle_n_o |-> $countones(~module_sel_n_o) <= 1)
      else $error("several modules selected");
   AST_ERR: assert property (
      tk && !ok |=> err_o && module_sel_n_o == 5'h1f)
      else $error("bad request not refused");
   AST_SEQ: assert property (
      tk && ok |=> ##1 !row_strobe_n_o ##3 !col_strobe_n_o [*3] ##1 done_o)
      else $error("strobe sequence wrong");
   AST_WR: assert property (
      tk && ok && req_i.write |=> ##4 !write_strobe_n_o [*3]
      ##1 write_strobe_n_o)
      else $error("write strobe wrong");
   AST_WR_ONLY: assert property (
      !write_strobe_n_o |-> read_drive_enable_n_o && data_n_oe_o
      && check_bits_n_oe_o)
      else $error("write strobe outside write");
   AST_RD: assert property (
      tk && ok && !req_i.write |=> !read_drive_enable_n_o && !data_n_oe_o)
      else $error("read enable wrong");
   AST_REF: assert property (
      $fell(refresh_cycle_n_o) |-> module_sel_n_o == 5'h00
      ##1 !row_strobe_n_o && col_strobe_n_o)
      else $error("refresh select wrong");
   AST_ROW: assert property (
      $fell(row_strobe_n_o) |-> $stable(addr_o) && $stable(module_sel_n_o))
      else $error("row address moved");
   AST_COL: assert property (
      $fell(col_strobe_n_o) |-> !row_strobe_n_o && $stable(addr_o))
      else $error("column address moved");
endmodule
bind mab_array_ctrl mab_array_ctrl_asserts u_chk (.sys_clk_i(sys_clk_i),
   .sys_rst_i(sys_rst_i), .req_valid_i(req_valid_i), .req_i(req_i),
   .req_ready_o(req_ready_o), .refresh_req_i(refresh_req_i),
   .done_o(done_o), .err_o(err_o), .module_present_o(module_present_o),
   .module_sel_n_o(module_sel_n_o), .addr_o(addr_o),
   .row_strobe_n_o(row_strobe_n_o), .col_strobe_n_o(col_strobe_n_o),
   .write_strobe_n_o(write_strobe_n_o),
   .read_drive_enable_n_o(read_drive_enable_n_o),
   .refresh_cycle_n_o(refresh_cycle_n_o), .data_n_oe_o(data_n_oe_o),
   .check_bits_n_oe_o(check_bits_n_oe_o));

// ===== memory_array_bus_control_bench.sv
// Self-checking bench for the memory array bus controller
`timescale 1ns/10ps
module memory_array_bus_control_bench
   import mab_pkg::*;
   ;
   logic sys_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic req_valid_i = 1'b0;
   logic refresh_req_i = 1'b0;
   mab_req_s req_i = '0;
   mab_rsp_s rsp;
   logic rdy, done, err, row_n, col_n, wr_n, rd_n, ref_n, doe, coe;
   logic [4:0] pres, sel_n;
   logic [1:0] bank;
   logic [7:0] addr;
   logic [7:0] ref_row = 8'h00;
   logic [31:0] d_o;
   logic [6:0] c_o;
   logic [38:0] mdl, pins;
   logic [9:0] fp_n;
   // Module 4 left out so the refusal path is reached
   localparam logic [4:0] ABSENT_MODS = 5'h10;
   int bad_count = 0;
   int num_checks = 0;
   int cyc = 0;
   // Wire level: whoever enables drives, else the model
   assign pins = {doe ? d_o : mdl[38:7], coe ? c_o : mdl[6:0]};
   always #12.5 sys_clk_i = ~sys_clk_i;
   mab_array_ctrl DUT (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
      .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(rdy),
      .refresh_req_i(refresh_req_i), .done_o(done), .err_o(err),
      .rsp_o(rsp), .module_present_o(pres), .module_sel_n_o(sel_n),
      .bank_pick_o(bank), .addr_o(addr), .row_strobe_n_o(row_n),
      .col_strobe_n_o(col_n), .write_strobe_n_o(wr_n),
      .read_drive_enable_n_o(rd_n), .refresh_cycle_n_o(ref_n),
      .data_n_i(pins[38:7]), .data_n_o(d_o), .data_n_oe_o(doe),
      .check_bits_n_i(pins[6:0]), .check_bits_n_o(c_o),
      .check_bits_n_oe_o(coe), .module_presence_code_n_i(fp_n));
   mab_array_model #(.ABSENT(ABSENT_MODS)) u_mdl (.sys_clk_i(sys_clk_i),
      .sel_n_i(sel_n), .bank_i(bank), .addr_i(addr), .row_n_i(row_n),
      .col_n_i(col_n),
      .wr_n_i(wr_n), .rd_n_i(rd_n), .pins_i(pins), .pins_o(mdl),
      .pres_n_o(fp_n));
   ////////////////////////////////////////
   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [38:0] e, g);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_i);
      #2;
   endtask
   // Stops at c1 when refused, else at c9 with ready back
   task automatic access(input logic w, input logic [2:0] m,
      input logic [1:0] b, input logic [7:0] r, c, input logic [38:0] v);
      req_i = {w, m, b, r, c, v};
      req_valid_i = 1'b1;
      while (rdy !== 1'b1) tick(1);
      tick(1);
      req_valid_i = 1'b0;
      if (m > 3'h4 || ABSENT_MODS[m]) begin
         chk("err", 1, err);
         chk("sel", 5'h1f, sel_n);
         tick(1);
         return;
      end
      chk("sel", 5'(~(5'h1 << m)), sel_n);
      chk("bank", b, bank);
      chk("row", r, addr);
      chk("rd", w, rd_n);
      chk("oe", {w, w}, {doe, coe});
      if (w) chk("wdat", ~v, {d_o, c_o});
      tick(3);
      chk("col", c, addr);
      chk("rowstb", 0, row_n);
      tick(1);
      chk("colstb", 0, col_n);
      chk("wrstb", !w, wr_n);
      tick(3);
      chk("done", 1, done);
      chk("rowrel", 1, row_n);
      if (!w) chk("rdat", v, rsp);
      tick(2);
   endtask
   task automatic pat(input logic w, input int i);
      access(w, 3'(i), 2'(i), 8'hfe + 8'(i), 8'h3f * 8'(i),
         39'h5ac3a50f1e + 39'(i));
   endtask
   task automatic refresh;
      refresh_req_i = 1'b1;
      while (ref_n !== 1'b0) tick(1);
      refresh_req_i = 1'b0;
      chk("rsel", 0, sel_n);
      chk("raddr", ref_row, addr);
      ref_row++;
      tick(1);
      chk("rref", 2'h1, {row_n, col_n});
      tick(7);
   endtask
   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc > 3000) begin
         bad_count++;
         complete_run;
      end
   end
   initial begin
      tick(4);
      chk("idle", 6'h3e, {row_n, col_n, wr_n, rd_n, ref_n, rdy});
      sys_rst_i = 1'b0;
      tick(4);
      chk("pres", 5'(~ABSENT_MODS), pres);
      for (int i = 0; i < 4; i++) pat(1, i);
      for (int i = 0; i < 4; i++) pat(0, i);
      access(0, 3'h4, 2'h0, 8'h00, 8'h00, 39'h0);
      access(0, 3'h7, 2'h1, 8'h00, 8'h00, 39'h0);
      refresh();
      refresh();
      pat(0, 1);
      complete_run;
   end
endmodule
